/* File: hw/mrb_bits.sv */
// mrb_bits: one 16-bit register whose bits each follow their own access
// assumes: single clock domain, event and done inputs are synchronous
`timescale 1ns/1ps
`default_nettype none
module mrb_bits #(
  parameter logic [47:0] ACC = 48'h0,
  parameter logic [31:0] DEF = 32'h0,
  parameter logic [47:0] PIN_SEL = 48'h0
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // strap sample and reload
  input wire logic [4:0] strap,
  input wire logic strap_load,
  // access strobes
  input wire logic wr,
  input wire logic rd_done,
  input wire logic ovr_en,
  input wire logic [15:0] wdata,
  // monitored signals
  input wire logic [15:0] event_in,
  input wire logic [15:0] done_in,
  // stored value
  output logic [15:0] value
);
  logic [15:0] next_value;
  logic [15:0] def_val;

  // per-bit default value from its encoded source
  always_comb
  begin
    for (int i = 0; i < mrb_pkg::REG_W; i++)
    begin
      unique case (DEF[2*i +: 2])
        mrb_pkg::DEF_ONE: def_val[i] = 1'b1;
        mrb_pkg::DEF_PIN: def_val[i] = strap[PIN_SEL[3*i +: 3]];
        default: def_val[i] = 1'b0;
      endcase
    end
  end

  // per-bit next value, each bit by its own access type
  always_comb
  begin
    next_value = value;
    for (int i = 0; i < mrb_pkg::REG_W; i++)
    begin
      unique case (ACC[3*i +: 3])
        mrb_pkg::ACC_RW:
          if (wr) next_value[i] = wdata[i];
        mrb_pkg::ACC_OGW:
          if (wr && ovr_en) next_value[i] = wdata[i];
        mrb_pkg::ACC_WZO:
          if (wr && !wdata[i]) next_value[i] = 1'b0;
        mrb_pkg::ACC_LHE:
          // the reload after a read wins over the set
          if (rd_done) next_value[i] = event_in[i];
          else if (event_in[i]) next_value[i] = 1'b1;
        mrb_pkg::ACC_LLE:
          if (rd_done) next_value[i] = event_in[i];
          else if (!event_in[i]) next_value[i] = 1'b0;
        mrb_pkg::ACC_SCT:
          if (wr && wdata[i]) next_value[i] = 1'b1;
          else if (done_in[i]) next_value[i] = 1'b0;
        default: next_value[i] = value[i]; // read-only
      endcase
      if (strap_load) next_value[i] = def_val[i];
    end
  end

  // register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) value <= 16'h0000;
    else value <= next_value;
  end
endmodule
`default_nettype wire

/* File: hw/mrb_pkg.sv */
// mrb_pkg: constants for the management register bit-access bank
// assumes: used by mrb_top and mrb_bits; nothing imported anywhere
package mrb_pkg;
  // ---------------------------------------------------------------
  // access-type encodings per bit
  // ---------------------------------------------------------------
  localparam logic [2:0] ACC_RO = 3'h0; // read-only
  localparam logic [2:0] ACC_RW = 3'h1; // plain read/write
  localparam logic [2:0] ACC_OGW = 3'h2; // override_gated_write
  localparam logic [2:0] ACC_WZO = 3'h3; // write_zero_only
  localparam logic [2:0] ACC_LHE = 3'h4; // latch_high_event
  localparam logic [2:0] ACC_LLE = 3'h5; // latch_low_event
  localparam logic [2:0] ACC_SCT = 3'h6; // self_clearing_trigger
  // ---------------------------------------------------------------
  // default-source encodings per bit
  // ---------------------------------------------------------------
  localparam logic [1:0] DEF_NONE = 2'h0; // no default, cleared to 0
  localparam logic [1:0] DEF_ZERO = 2'h1;
  localparam logic [1:0] DEF_ONE = 2'h2;
  localparam logic [1:0] DEF_PIN = 2'h3; // strap level latched once after reset release
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int NUM_REGS = 4;
  localparam int ADDR_W = 2;
  localparam int STRAP_W = 5;
  localparam int STRAP_SEL_W = 3;
  // override control bit: register 0, bit 15 of this bank
  localparam logic [1:0] OVR_REG = 2'h0;
  localparam int OVR_BIT = 15;
  // unmapped read answer
  localparam logic [15:0] UNMAPPED_DATA = 16'hFFFF;
endpackage

/* File: hw/mrb_top.sv */
// mrb_top: management register bank with per-bit access types
// assumes: a frame decoder supplies one-cycle read/write strobes on mclk;
// strap pins and event inputs come from outside and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module mrb_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register access from the frame decoder
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [4:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  output logic [15:0] acc_rdata,
  output logic acc_rvalid,
  // strap pins
  input wire logic strap_addr0_indicator_pin,
  input wire logic strap_addr1_indicator_pin,
  input wire logic strap_addr2_indicator_pin,
  input wire logic strap_addr3_indicator_pin,
  input wire logic strap_addr4_indicator_pin,
  // monitored events and trigger completion
  input wire logic [15:0] evt_async,
  input wire logic [15:0] trig_done,
  // register contents to the device
  output logic [15:0] ctrl_q,
  output logic [15:0] cfg_q,
  output logic [15:0] stat_q,
  output logic [15:0] ext_q
);
  // ---------------------------------------------------------------
  // reset release and input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  logic [4:0] strap_s1, strap_s2, strap_hold, next_strap_hold;
  logic [15:0] evt_s1, evt_s2;
  logic strap_load, next_strap_load;

  // reset released through two flops
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // two-flop synchronisers for pins and events
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_s1 <= 5'h00;
      strap_s2 <= 5'h00;
      evt_s1 <= 16'h0000;
      evt_s2 <= 16'h0000;
    end
    else
    begin
      strap_s1 <= {strap_addr4_indicator_pin, strap_addr3_indicator_pin,
        strap_addr2_indicator_pin, strap_addr1_indicator_pin,
        strap_addr0_indicator_pin};
      strap_s2 <= strap_s1;
      evt_s1 <= evt_async;
      evt_s2 <= evt_s1;
    end
  end

  // ---------------------------------------------------------------
  // strap capture after release
  // ---------------------------------------------------------------
  logic [1:0] cap_cnt, next_cap_cnt;

  // wait two cycles for synchronisers, then latch straps once
  always_comb
  begin
    next_cap_cnt = cap_cnt;
    next_strap_hold = strap_hold;
    next_strap_load = 1'b0;
    if (cap_cnt != 2'h3)
    begin
      next_cap_cnt = cap_cnt + 2'h1;
      if (cap_cnt == 2'h2)
      begin
        next_strap_hold = strap_s2;
        next_strap_load = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_cnt <= 2'h0;
      strap_hold <= 5'h00;
      strap_load <= 1'b0;
    end
    else
    begin
      cap_cnt <= next_cap_cnt;
      strap_hold <= next_strap_hold;
      strap_load <= next_strap_load;
    end
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input int r);
    hit = (a[4:mrb_pkg::ADDR_W] == '0) &&
      (a[mrb_pkg::ADDR_W-1:0] == r[mrb_pkg::ADDR_W-1:0]);
  endfunction

  logic busy;
  logic ovr_en;
  logic [3:0] wr_sel, rd_sel;
  assign busy = (cap_cnt != 2'h3) || strap_load; // accesses isolated
  assign ovr_en = ctrl_q[mrb_pkg::OVR_BIT];

  // per-register strobes; unmapped writes reach no register, but still consume the override
  always_comb
  begin
    for (int r = 0; r < mrb_pkg::NUM_REGS; r++)
    begin
      wr_sel[r] = acc_wr && !busy && hit(acc_addr, r);
      rd_sel[r] = acc_rd && !busy && hit(acc_addr, r);
    end
  end

  // ---------------------------------------------------------------
  // register 0: override bit (15), rw and trigger bits
  // register 1: override-gated, write-zero-only, read-only bits
  // register 2: latch-high and latch-low event bits
  // register 3: strap-defaulted and fixed-default bits
  // ---------------------------------------------------------------
  logic [15:0] ctrl_wdata;
  logic ovr_ctrl_clr;
  // any register write consumes the override; a write to reg 0 cannot re-arm, as its bit 15 is forced low while armed
  assign ovr_ctrl_clr = acc_wr && !busy && ovr_en;
  always_comb
  begin
    ctrl_wdata = acc_wdata;
    if (ovr_en) ctrl_wdata[mrb_pkg::OVR_BIT] = 1'b0;
  end

  // reg 0 override bit updated by writes; self-cleared on consumption
  logic next_ovr, ovr_q;
  always_comb
  begin
    next_ovr = ovr_q;
    if (wr_sel[0]) next_ovr = ctrl_wdata[mrb_pkg::OVR_BIT];
    else if (ovr_ctrl_clr) next_ovr = 1'b0;
    if (strap_load) next_ovr = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) ovr_q <= 1'b0;
    else ovr_q <= next_ovr;
  end

  logic [15:0] r0_low;
  assign ctrl_q = {ovr_q, r0_low[14:0]};

  mrb_bits #(
    .ACC({3'h0, {7{3'h1}}, {8{3'h6}}}),
    .DEF({2'h1, {15{2'h1}}}),
    .PIN_SEL(48'h0)
  ) u_r0 (
    .mclk(mclk), .rst_n(rst_n), .strap(strap_hold),
    .strap_load(strap_load), .wr(wr_sel[0]), .rd_done(1'b0),
    .ovr_en(1'b0), .wdata(ctrl_wdata), .event_in(16'h0000),
    .done_in(trig_done), .value(r0_low)
  );

  mrb_bits #(
    .ACC({{8{3'h2}}, {4{3'h3}}, {4{3'h0}}}),
    .DEF({{8{2'h1}}, {4{2'h2}}, {4{2'h0}}}),
    .PIN_SEL(48'h0)
  ) u_r1 (
    .mclk(mclk), .rst_n(rst_n), .strap(strap_hold),
    .strap_load(strap_load), .wr(wr_sel[1]), .rd_done(1'b0),
    .ovr_en(ovr_en), .wdata(acc_wdata), .event_in(16'h0000),
    .done_in(16'h0000), .value(cfg_q)
  );

  mrb_bits #(
    .ACC({{8{3'h5}}, {8{3'h4}}}),
    .DEF({{8{2'h2}}, {8{2'h1}}}),
    .PIN_SEL(48'h0)
  ) u_r2 (
    .mclk(mclk), .rst_n(rst_n), .strap(strap_hold),
    .strap_load(strap_load), .wr(wr_sel[2]), .rd_done(rd_sel[2]),
    .ovr_en(1'b0), .wdata(acc_wdata), .event_in(evt_s2),
    .done_in(16'h0000), .value(stat_q)
  );

  mrb_bits #(
    .ACC({{11{3'h1}}, {5{3'h1}}}),
    .DEF({{11{2'h1}}, {5{2'h3}}}),
    .PIN_SEL({33'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0})
  ) u_r3 (
    .mclk(mclk), .rst_n(rst_n), .strap(strap_hold),
    .strap_load(strap_load), .wr(wr_sel[3]), .rd_done(1'b0),
    .ovr_en(1'b0), .wdata(acc_wdata), .event_in(16'h0000),
    .done_in(16'h0000), .value(ext_q)
  );

  // ---------------------------------------------------------------
  // read data: registered, one cycle after the strobe
  // ---------------------------------------------------------------
  logic [15:0] next_rdata;
  logic next_rvalid;
  always_comb
  begin
    next_rvalid = acc_rd && !busy;
    unique case (rd_sel)
      4'h1: next_rdata = ctrl_q;
      4'h2: next_rdata = cfg_q;
      4'h4: next_rdata = stat_q; // history value; reload follows
      4'h8: next_rdata = ext_q;
      default: next_rdata = mrb_pkg::UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_rdata <= 16'h0000;
      acc_rvalid <= 1'b0;
    end
    else
    begin
      acc_rdata <= next_rdata;
      acc_rvalid <= next_rvalid;
    end
  end
endmodule
`default_nettype wire

/* File: tb/mgmt_register_bit_access_bench.sv */
// mgmt_register_bit_access_bench: self-checking bench for mrb_top
// assumes: mrb_sta drives the access port, bench drives pins and events
`timescale 1ns/1ps
`default_nettype none
module mgmt_register_bit_access_bench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] strap = 5'h15;
  logic [15:0] evt = 16'hFF00;
  logic [15:0] done = 16'h0000;
  logic acc_wr, acc_rd, acc_rvalid;
  logic [4:0] acc_addr;
  logic [15:0] acc_wdata, acc_rdata, ctrl_q, cfg_q, stat_q, ext_q, d;
  int failures = 0;
  int checked = 0;
  always #4 mclk = ~mclk;
  mrb_sta sta (.mclk(mclk), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata));
  mrb_top DUT (.mclk(mclk), .rstn(rstn), .acc_wr(acc_wr), .acc_rd(acc_rd),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .acc_rvalid(acc_rvalid), .strap_addr0_indicator_pin(strap[0]),
    .strap_addr1_indicator_pin(strap[1]), .strap_addr2_indicator_pin(strap[2]),
    .strap_addr3_indicator_pin(strap[3]), .strap_addr4_indicator_pin(strap[4]),
    .evt_async(evt), .trig_done(done), .ctrl_q(ctrl_q), .cfg_q(cfg_q),
    .stat_q(stat_q), .ext_q(ext_q));
  // ---------------------------------------------------------------
  // compare, reset and closing helpers
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic do_reset(input logic [4:0] s);
    rstn = 1'b0;
    strap = s;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    repeat (10) @(negedge mclk);
  endtask
  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults(input logic [4:0] s);
    chk("ctrl", 16'h0000, ctrl_q);
    chk("cfg", 16'h00F0, cfg_q);
    chk("stat", 16'hFF00, stat_q);
    chk("ext", {11'h000, s}, ext_q);
    sta.rd(5'h01, d);
    chk("rd cfg", 16'h00F0, d);
    $display("defaults done");
  endtask
  task automatic t_access;
    sta.wr(5'h01, 16'hFFFF);
    chk("gated", 16'h00F0, cfg_q);
    sta.wr(5'h00, 16'h8000);
    chk("ovr set", 16'h8000, ctrl_q);
    sta.wr(5'h01, 16'hAB00);
    chk("ovr write", 16'hAB00, cfg_q);
    chk("ovr clr", 16'h0000, ctrl_q);
    sta.wr(5'h01, 16'h0000);
    chk("regated", 16'hAB00, cfg_q);
    sta.wr(5'h03, 16'hA5F5);
    chk("rw", 16'hA5F5, ext_q);
    // low address bits of 0B match register 3, so aliasing would show
    sta.wr(5'h0B, 16'h1234);
    chk("unmapped wr", 16'hA5F5, ext_q);
    sta.rd(5'h09, d);
    chk("unmapped", 16'hFFFF, d);
    $display("access done");
  endtask
  task automatic t_latch;
    evt = 16'hFE01;
    repeat (2) @(negedge mclk);
    evt = 16'hFF00;
    repeat (4) @(negedge mclk);
    sta.rd(5'h02, d);
    chk("latch hist", 16'hFE01, d);
    sta.rd(5'h02, d);
    chk("latch live", 16'hFF00, d);
    $display("latch done");
  endtask
  task automatic t_trig;
    sta.wr(5'h00, 16'h0001);
    chk("trig set", 16'h0001, ctrl_q);
    repeat (3) @(negedge mclk);
    chk("trig held", 16'h0001, ctrl_q);
    done = 16'h0001;
    @(negedge mclk);
    done = 16'h0000;
    chk("trig clr", 16'h0000, ctrl_q);
    $display("trigger done");
  endtask
  initial
  begin
    do_reset(5'h15);
    t_defaults(5'h15);
    t_access;
    t_latch;
    t_trig;
    do_reset(5'h0A);
    t_defaults(5'h0A);
    test_done;
  end
  // watchdog for a hung access
  initial
  begin
    #50000;
    failures++;
    test_done;
  end
endmodule
`default_nettype wire

/* File: tb/mrb_sta.sv */
// mrb_sta: station side model issuing register reads and writes
// assumes: tasks are entered at a falling edge of mclk
`timescale 1ns/1ps
`default_nettype none
module mrb_sta (
  // clock
  input wire logic mclk,
  // answer from the bank
  input wire logic [15:0] acc_rdata,
  input wire logic acc_rvalid,
  // requests
  output logic acc_wr,
  output logic acc_rd,
  output logic [4:0] acc_addr,
  output logic [15:0] acc_wdata
);
  initial
  begin
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_addr = 5'h00;
    acc_wdata = 16'h0000;
  end
  // one-cycle write; callers pass reserved bits at their defaults
  // an idle cycle follows so a second call always re-raises the strobe
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    acc_addr = a;
    acc_wdata = d;
    acc_wr = 1'b1;
    @(negedge mclk);
    acc_wr = 1'b0;
    acc_wdata = ~d; // released data no longer shows the old value
    @(negedge mclk);
  endtask
  // one-cycle read, data taken while the answer stands
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    acc_addr = a;
    acc_rd = 1'b1;
    @(negedge mclk);
    acc_rd = 1'b0;
    n = 0;
    while (acc_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    // a missing answer hands back unknowns so the caller's compare fails
    if (acc_rvalid !== 1'b1) d = 16'hXXXX;
    else d = acc_rdata;
    @(negedge mclk);
  endtask
endmodule
`default_nettype wire

/* File: tb/mrb_top_props.sv */
// mrb_top_props: timing checks on the register bank ports
// assumes: one mclk domain, rstn low resets the bank
`timescale 1ns/1ps
`default_nettype none
module mrb_top_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // access
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [4:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  input wire logic [15:0] acc_rdata,
  input wire logic acc_rvalid,
  // events and contents
  input wire logic [15:0] trig_done,
  input wire logic [15:0] ctrl_q,
  input wire logic [15:0] cfg_q,
  input wire logic [15:0] stat_q,
  input wire logic [15:0] ext_q
);
  // ---------------------------------------------------------------
  // ready once the post-reset busy span is over
  // ---------------------------------------------------------------
  logic [2:0] cnt;
  logic rdy;
  assign rdy = cnt == 3'h7;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn) cnt <= 3'h0;
    else if (!rdy) cnt <= cnt + 3'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_rvalid;
    rdy && acc_rd |=> acc_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("no read answer");
  property p_unmapped;
    rdy && acc_rd && acc_addr > 5'h03 |=> acc_rdata == 16'hFFFF;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped");
  property p_ro;
    rdy |-> cfg_q[3:0] == 4'h0;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only bits moved");
  property p_gate;
    rdy && acc_wr && acc_addr == 5'h01 && !ctrl_q[15] |=> $stable(cfg_q[15:8]);
  endproperty
  a_gate: assert property (p_gate) else $error("gated write taken");
  property p_ovr;
    rdy && acc_wr && acc_addr == 5'h01 && ctrl_q[15]
      |=> cfg_q[15:8] == $past(acc_wdata[15:8]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override write lost");
  property p_selfclr;
    rdy && acc_wr && acc_addr < 5'h04 && ctrl_q[15]
      && !(acc_addr == 5'h00 && acc_wdata[15]) |=> !ctrl_q[15];
  endproperty
  a_selfclr: assert property (p_selfclr) else $error("override stuck");
  property p_rw;
    rdy && acc_wr && acc_addr == 5'h03 |=> ext_q[15:5] == $past(acc_wdata[15:5]);
  endproperty
  a_rw: assert property (p_rw) else $error("rw bits not stored");
  property p_wzo;
    rdy && $past(rdy) |-> (cfg_q[7:4] & ~$past(cfg_q[7:4])) == 4'h0;
  endproperty
  a_wzo: assert property (p_wzo) else $error("zero-only bit set");
  property p_hold;
    rdy && stat_q[0] && !acc_rd |=> stat_q[0];
  endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_trig;
    rdy && ctrl_q[0] && trig_done[0] && !(acc_wr && acc_addr == 5'h00)
      |=> !ctrl_q[0];
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not cleared");
  // main scenarios
  c_stat: cover property (rdy && acc_rd && acc_addr == 5'h02);
  c_ovr: cover property (rdy && acc_wr && ctrl_q[15]);
  c_trig: cover property (rdy && ctrl_q[0] && trig_done[0]);
endmodule
bind mrb_top mrb_top_props u_props (.mclk(mclk), .rstn(rstn),
  .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_addr(acc_addr),
  .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
  .trig_done(trig_done), .ctrl_q(ctrl_q), .cfg_q(cfg_q), .stat_q(stat_q),
  .ext_q(ext_q));
`default_nettype wire
